// ### shared/fsps_defs.svh
// Offsets, field positions, command codes and counts of the flash self-program sequencer
`ifndef FSPS_DEFS_SVH
`define FSPS_DEFS_SVH

// ==========================================
// Register map
`define FSPS_ADDR_W 12
`define FSPS_CTRL_OFFSET 12'h000
`define FSPS_CTRL_RESET 8'h00

// ==========================================
// Control/status field positions
`define FSPS_EN_BIT 0
`define FSPS_ERASE_BIT 1
`define FSPS_WRITE_BIT 2
`define FSPS_FUSE_BIT 3
`define FSPS_CLEAR_BIT 4
`define FSPS_SIG_BIT 5
`define FSPS_RWW_BIT 6
`define FSPS_CODE_W 6

// ==========================================
// Command codes in the lower six bits
`define FSPS_CODE_NONE 6'h00
`define FSPS_CODE_LOAD 6'h01
`define FSPS_CODE_ERASE 6'h03
`define FSPS_CODE_WRITE 6'h05
`define FSPS_CODE_CLEAR 6'h11

// ==========================================
// Arming window and pointer layout
`define FSPS_WINDOW_W 3
`define FSPS_WINDOW_CYCLES 3'h4
`define FSPS_WORD_LSB 1
`define FSPS_WORD_BITS 6
`define FSPS_PAGE_LSB 7
`define FSPS_PAGE_BITS 7
`define FSPS_BUF_DEPTH 64
`define FSPS_ERASED_WORD 16'hffff

`endif

// ### shared/fsps_pkg.sv
// Types shared by the flash self-program sequencer and its page buffer
package fsps_pkg;
    `include "fsps_defs.svh"

    typedef enum logic [1:0] {
        FSPS_IDLE = 2'b00,
        FSPS_ARMED = 2'b01,
        FSPS_ERASE = 2'b10,
        FSPS_WRITE = 2'b11
    } fsps_state_t;

    // One store instruction from the core: pointer pair and data pair
    typedef struct packed {
        logic [7:0] pointer_high_byte;
        logic [7:0] pointer_low_byte;
        logic [15:0] data;
    } fsps_store_t;

    // Command to the flash array
    typedef struct packed {
        logic erase;
        logic write;
        logic [`FSPS_PAGE_BITS-1:0] page;
    } fsps_flash_cmd_t;
endpackage

// ### rtl/fsps_page_buffer.sv
// Temporary page buffer with per-word loaded flags
`timescale 1ns/10ps
`include "fsps_defs.svh"
module fsps_page_buffer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [`FSPS_WORD_BITS-1:0] wr_idx,
    input wire logic [15:0] wr_data,
    input wire logic clear,
    input wire logic [`FSPS_WORD_BITS-1:0] rd_idx,
    output logic [15:0] rd_data_q,
    output logic loaded
);
    import fsps_pkg::*;

    logic [15:0] mem [0:`FSPS_BUF_DEPTH-1];
    logic [`FSPS_BUF_DEPTH-1:0] valid_q;

    // Second load to a filled word is dropped until a clear
    wire write_ok = wr_en & ~valid_q[wr_idx];

    assign loaded = |valid_q;

    // ==========================================
    // Storage
    always_ff @(posedge pclk) begin
        if (write_ok) begin
            mem[wr_idx] <= wr_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_q <= '0;
        end else if (clear) begin
            valid_q <= '0;
        end else if (write_ok) begin
            valid_q[wr_idx] <= 1'b1;
        end
    end

    // Unloaded words read as erased flash
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data_q <= `FSPS_ERASED_WORD;
        end else begin
            rd_data_q <= valid_q[rd_idx] ? mem[rd_idx] : `FSPS_ERASED_WORD;
        end
    end
endmodule

// ### rtl/fsps_sequencer.sv
// Flash self-program sequencer: control register, arming window, erase/write/load
//
// Function
// - Code 03 then store within four cycles starts page erase, data ignored.
// - Core is halted for the whole page erase.
// - Erase uses only the page field of the pointer.
// - Code 01 then store within four cycles loads data word into buffer.
// - Word field of the pointer selects the buffer location.
// - Buffer clears after a page write and on the clear command.
// - Reset clears the buffer.
// - EEPROM write during page loading discards loaded buffer data.
// - Code 05 then store within four cycles writes buffer to page.
// - Core is halted for the whole page write.
// - Buffer may be filled before erase or between erase and write.
// - Buffer words may be loaded in any order.
// - Pointer is high byte from register 31, low byte from 30.
// - Low pointer bits select word in page, high bits select page.
// - Load-byte instruction uses pointer bit zero as byte select.
// - Enable clears after store or four idle cycles; held while busy.
// - Undefined codes in lower six bits have no effect.
// - Running EEPROM write blocks all self-programming.
`timescale 1ns/10ps
`include "fsps_defs.svh"
module fsps_sequencer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [`FSPS_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic store_valid,
    input wire fsps_pkg::fsps_store_t store_req,
    input wire logic lpm_valid,
    input wire logic [15:0] lpm_pointer,
    output logic [14:0] flash_rd_word_addr,
    input wire logic [15:0] flash_rdata,
    output logic [7:0] lpm_byte_q,
    output logic lpm_byte_valid_q,
    output fsps_pkg::fsps_flash_cmd_t flash_cmd_q,
    input wire logic flash_done,
    input wire logic [`FSPS_WORD_BITS-1:0] flash_buf_idx,
    output logic [15:0] flash_buf_word,
    input wire logic eeprom_busy,
    output logic cpu_halt
);
    import fsps_pkg::*;

    // ==========================================
    // Pointer decoding
    // page field above word field
    function automatic logic [`FSPS_PAGE_BITS-1:0] page_of(input logic [15:0] ptr);
        page_of = ptr[`FSPS_PAGE_LSB +: `FSPS_PAGE_BITS];
    endfunction

    function automatic logic [`FSPS_WORD_BITS-1:0] word_of(input logic [15:0] ptr);
        word_of = ptr[`FSPS_WORD_LSB +: `FSPS_WORD_BITS];
    endfunction

    fsps_state_t state_q, state_d;
    logic [`FSPS_CODE_W-1:0] cmd_q, cmd_d;
    logic [`FSPS_WINDOW_W-1:0] win_q, win_d;
    logic [31:0] prdata_q;
    logic eeprom_busy_q;
    logic buf_loaded;

    // pointer pair from registers 31 and 30
    wire [15:0] store_ptr = {store_req.pointer_high_byte, store_req.pointer_low_byte};

    // ==========================================
    // APB decode
    wire apb_setup = psel & ~penable;
    wire apb_access = psel & penable;
    wire ctrl_hit = (paddr == `FSPS_CTRL_OFFSET);
    wire wr_ctrl = apb_access & pwrite & ctrl_hit;
    wire [`FSPS_CODE_W-1:0] wr_code = pwdata[`FSPS_CODE_W-1:0];

    wire code_ok = (wr_code == `FSPS_CODE_LOAD) | (wr_code == `FSPS_CODE_ERASE)
                 | (wr_code == `FSPS_CODE_WRITE) | (wr_code == `FSPS_CODE_CLEAR);
    wire can_arm = (state_q == FSPS_IDLE) | (state_q == FSPS_ARMED);
    // no arming while the EEPROM is written
    // load arms in idle, before or after an erase
    wire arm = wr_ctrl & code_ok & can_arm & ~eeprom_busy;

    // Enable and command bits are live cmd_q; bits 7:6 read zero
    wire [7:0] ctrl_view = {2'b00, cmd_q};

    assign pready = 1'b1;
    assign pslverr = apb_access & ~ctrl_hit;
    assign prdata = prdata_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
        end else if (apb_setup) begin
            prdata_q <= (ctrl_hit & ~pwrite) ? {24'h0, ctrl_view} : 32'h0;
        end
    end

    // ==========================================
    // Store instruction handling
    // store only acts inside an open window
    wire store_hit = store_valid & (state_q == FSPS_ARMED) & ~eeprom_busy;
    wire do_load = store_hit & (cmd_q == `FSPS_CODE_LOAD);
    wire do_erase = store_hit & (cmd_q == `FSPS_CODE_ERASE);
    wire do_write = store_hit & (cmd_q == `FSPS_CODE_WRITE);
    wire busy = (state_q == FSPS_ERASE) | (state_q == FSPS_WRITE);
    wire write_end = (state_q == FSPS_WRITE) & flash_done;
    wire eeprom_start = eeprom_busy & ~eeprom_busy_q;

    assign cpu_halt = busy;

    // window of four edges, enable held while busy
    always_comb begin
        state_d = state_q;
        cmd_d = cmd_q;
        win_d = win_q;
        case (state_q)
            FSPS_IDLE: begin
                if (arm) begin
                    state_d = FSPS_ARMED;
                    cmd_d = wr_code;
                    win_d = `FSPS_WINDOW_CYCLES;
                end
            end
            FSPS_ARMED: begin
                win_d = win_q - 3'h1;
                if (do_erase) begin
                    state_d = FSPS_ERASE;
                end else if (do_write) begin
                    state_d = FSPS_WRITE;
                end else if (store_hit) begin
                    state_d = FSPS_IDLE;
                    cmd_d = `FSPS_CODE_NONE;
                end else if (arm) begin
                    cmd_d = wr_code;
                    win_d = `FSPS_WINDOW_CYCLES;
                end else if (win_q == 3'h1) begin
                    state_d = FSPS_IDLE;
                    cmd_d = `FSPS_CODE_NONE;
                end
            end
            FSPS_ERASE, FSPS_WRITE: begin
                if (flash_done) begin
                    state_d = FSPS_IDLE;
                    cmd_d = `FSPS_CODE_NONE;
                end
            end
            default: begin
                state_d = FSPS_IDLE;
                cmd_d = `FSPS_CODE_NONE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= FSPS_IDLE;
            cmd_q <= `FSPS_CODE_NONE;
            win_q <= 3'h0;
            eeprom_busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cmd_q <= cmd_d;
            win_q <= win_d;
            eeprom_busy_q <= eeprom_busy;
        end
    end

    // ==========================================
    // Flash array command
    // erase starts on armed store
    // only the page field reaches the array
    // write programs buffer into selected page
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_cmd_q <= '0;
        end else if (do_erase | do_write) begin
            flash_cmd_q.erase <= do_erase;
            flash_cmd_q.write <= do_write;
            flash_cmd_q.page <= page_of(store_ptr);
        end else if (busy & flash_done) begin
            flash_cmd_q.erase <= 1'b0;
            flash_cmd_q.write <= 1'b0;
        end
    end

    // ==========================================
    // Temporary page buffer
    // clear after write or on clear command
    // EEPROM write drops a partly loaded buffer
    wire arm_clear = arm & (wr_code == `FSPS_CODE_CLEAR);
    wire buf_clear = arm_clear | write_end | (eeprom_start & buf_loaded);

    fsps_page_buffer u_page_buffer (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(do_load),
        .wr_idx(word_of(store_ptr)),
        .wr_data(store_req.data),
        .clear(buf_clear),
        .rd_idx(flash_buf_idx),
        .rd_data_q(flash_buf_word),
        .loaded(buf_loaded)
    );

    // ==========================================
    // Load-byte instruction
    // bit zero selects byte of word
    assign flash_rd_word_addr = lpm_pointer[15:1];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lpm_byte_q <= 8'h00;
            lpm_byte_valid_q <= 1'b0;
        end else begin
            lpm_byte_valid_q <= lpm_valid;
            if (lpm_valid) begin
                lpm_byte_q <= lpm_pointer[0] ? flash_rdata[15:8] : flash_rdata[7:0];
            end
        end
    end

    // ==========================================
    // Checks
    erase_start_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        do_erase |=> flash_cmd_q.erase && state_q == FSPS_ERASE)
        else $error("armed erase store did not start erase");

    erase_halt_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        flash_cmd_q.erase |-> cpu_halt)
        else $error("core not halted during erase");

    erase_page_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        store_hit && cmd_q == `FSPS_CODE_ERASE
        |=> flash_cmd_q.page == $past(store_ptr[`FSPS_PAGE_LSB +: `FSPS_PAGE_BITS]))
        else $error("erase page not taken from pointer page field");

    load_fill_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        do_load && !eeprom_busy |=> buf_loaded)
        else $error("armed load left buffer empty");

    write_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        write_end |=> !buf_loaded && !cpu_halt)
        else $error("buffer not cleared after page write");

    write_halt_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        flash_cmd_q.write |-> cpu_halt && state_q == FSPS_WRITE)
        else $error("core not halted during write");

    eeprom_drop_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        eeprom_busy && !eeprom_busy_q |=> !buf_loaded)
        else $error("loaded data survived an EEPROM write");

    window_expire_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        arm ##1 (!store_valid && !wr_ctrl)[*4] |=> state_q == FSPS_IDLE && cmd_q == 6'h00)
        else $error("enable not cleared four cycles after arming");

    busy_enable_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        cpu_halt |-> ctrl_view[`FSPS_EN_BIT])
        else $error("enable dropped while erase or write runs");

    bad_code_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_ctrl && !code_ok && state_q == FSPS_IDLE |=> state_q == FSPS_IDLE)
        else $error("undefined code changed state");

    eeprom_block_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        eeprom_busy && state_q == FSPS_IDLE |=> state_q == FSPS_IDLE)
        else $error("armed during EEPROM write");

    stray_store_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        store_valid && state_q == FSPS_IDLE |=> !cpu_halt && $stable(flash_cmd_q))
        else $error("unarmed store had an effect");

    halt_source_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        cpu_halt |-> flash_cmd_q.erase || flash_cmd_q.write)
        else $error("core halted with no erase or write running");

    halt_release_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        cpu_halt && flash_done |=> !cpu_halt && cmd_q == `FSPS_CODE_NONE)
        else $error("enable not cleared when erase or write ended");

    lpm_select_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        lpm_valid && lpm_pointer[0] |=> lpm_byte_q == $past(flash_rdata[15:8]))
        else $error("odd pointer did not select the high byte");
endmodule

// ### tb/fsps_core_model.sv
// Core and flash array model facing the self-program sequencer
`timescale 1ns/10ps
module fsps_core_model (
    input wire logic pclk,
    output fsps_pkg::fsps_store_t store_req,
    output logic store_valid,
    input wire fsps_pkg::fsps_flash_cmd_t flash_cmd_q,
    output logic flash_done,
    output logic [5:0] flash_buf_idx,
    input wire logic [15:0] flash_buf_word,
    input wire logic [14:0] flash_rd_word_addr,
    output logic [15:0] flash_rdata
);
    import fsps_pkg::*;
    logic [15:0] mem [8192];
    logic [6:0] pg;
    assign flash_rdata = mem[flash_rd_word_addr[12:0]];
    // ==========================================
    // Store instruction, one cycle; lines scrambled after
    // high byte then low byte
    task automatic store(input logic [15:0] ptr, input logic [15:0] d);
        store_valid <= 1;
        store_req <= {ptr, d};
        @(posedge pclk);
        store_valid <= 0;
        store_req <= ~{ptr, d};
    endtask
    // ==========================================
    // Flash array: erase or program, then done pulse
    initial begin
        store_valid = 0;
        store_req = '0;
        flash_done = 0;
        flash_buf_idx = '0;
        for (int i = 0; i < 8192; i++) mem[i] = 16'(i) ^ 16'h5a5a;
        forever begin
            @(posedge pclk);
            if (flash_cmd_q.erase === 1'b1 || flash_cmd_q.write === 1'b1) begin
                pg = flash_cmd_q.page;
                if (flash_cmd_q.erase === 1'b1) begin
                    repeat ($urandom_range(20, 2)) @(posedge pclk);
                    for (int i = 0; i < 64; i++) mem[{pg, 6'(i)}] = 16'hffff;
                end else begin
                    for (int i = 0; i < 64; i++) begin
                        flash_buf_idx <= 6'(i);
                        repeat (2) @(posedge pclk);
                        mem[{pg, 6'(i)}] = flash_buf_word;
                    end
                end
                flash_done <= 1;
                @(posedge pclk);
                flash_done <= 0;
            end
        end
    end
endmodule

// ### tb/testbench.sv
// Self-checking bench for the flash self-program sequencer
`timescale 1ns/10ps
`include "fsps_defs.svh"
module testbench;
    import fsps_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic store_valid, lpm_valid, lpm_byte_valid_q, flash_done, eeprom_busy, cpu_halt;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] lpm_pointer, flash_rdata, flash_buf_word, fw;
    logic [14:0] flash_rd_word_addr;
    logic [7:0] lpm_byte_q;
    logic [5:0] flash_buf_idx;
    fsps_store_t store_req;
    fsps_flash_cmd_t flash_cmd_q;
    int mismatches, samples_checked, bm[64];
    fsps_sequencer dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .store_valid(store_valid),
        .store_req(store_req), .lpm_valid(lpm_valid), .lpm_pointer(lpm_pointer),
        .flash_rd_word_addr(flash_rd_word_addr), .flash_rdata(flash_rdata),
        .lpm_byte_q(lpm_byte_q), .lpm_byte_valid_q(lpm_byte_valid_q),
        .flash_cmd_q(flash_cmd_q), .flash_done(flash_done), .flash_buf_idx(flash_buf_idx),
        .flash_buf_word(flash_buf_word), .eeprom_busy(eeprom_busy), .cpu_halt(cpu_halt));
    fsps_core_model core_u (.pclk(pclk), .store_req(store_req), .store_valid(store_valid),
        .flash_cmd_q(flash_cmd_q), .flash_done(flash_done), .flash_buf_idx(flash_buf_idx),
        .flash_buf_word(flash_buf_word), .flash_rd_word_addr(flash_rd_word_addr),
        .flash_rdata(flash_rdata));
    initial begin
        pclk = 0;
        forever #5 pclk = ~pclk;
    end
    // ==========================================
    // Tasks
    task automatic chk(input bit ok, input string m);
        samples_checked++;
        if (!ok) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic summarize();
        $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        chk(n == 1, "apb wait states");
    endtask
    task automatic load(input int k);
        int w;
        repeat (k) begin
            do w = $urandom_range(63, 0); while (bm[w] >= 0);
            bm[w] = $urandom_range(65535, 0);
            apb(1, 0, 32'(`FSPS_CODE_LOAD));
            repeat ($urandom_range(3, 0)) @(posedge pclk);
            core_u.store({2'b00, 7'($urandom), 6'(w), 1'(w)}, 16'(bm[w]));
        end
    endtask
    task automatic op(input logic [5:0] code, input logic [6:0] p);
        bit er;
        int n;
        er = (code == `FSPS_CODE_ERASE);
        apb(1, 0, 32'(code));
        core_u.store({er ? 2'b11 : 2'b00, p, er ? 7'($urandom) : 7'h00}, 16'($urandom));
        @(posedge pclk);
        chk(cpu_halt === 1 && flash_cmd_q === {er, !er, p}, "op start");
        n = 0;
        while (cpu_halt !== 1'b0 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        chk(n > 1 && n < 300 && flash_cmd_q.erase === 1'b0
            && flash_cmd_q.write === 1'b0, "op end");
        if (!er) begin
            for (int i = 0; i < 64; i++) begin
                fw = bm[i] < 0 ? 16'hffff : 16'(bm[i]);
                chk(core_u.mem[{p, 6'(i)}] === fw, "page data");
                bm[i] = -1;
            end
        end
    endtask
    // ==========================================
    // Main sequence
    initial begin
        presetn = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = '0;
        pwdata = '0;
        lpm_valid = 0;
        lpm_pointer = '0;
        eeprom_busy = 0;
        mismatches = 0;
        samples_checked = 0;
        foreach (bm[i]) bm[i] = -1;
        void'($urandom(87048));
        repeat (3) @(posedge pclk);
        presetn <= 1;
        apb(0, 0, 0);
        chk(rd === 32'h0, "control reset");
        apb(1, 12'h004, 32'h3);
        apb(0, 12'h004, 0);
        chk(err === 1 && rd === 0 && cpu_halt === 0, "unmapped");
        load(6);
        op(`FSPS_CODE_ERASE, 7'h15);
        op(`FSPS_CODE_WRITE, 7'h15);
        op(`FSPS_CODE_ERASE, 7'h6a);
        load(9);
        op(`FSPS_CODE_WRITE, 7'h6a);
        load(4);
        apb(1, 0, 32'(`FSPS_CODE_CLEAR));
        foreach (bm[i]) bm[i] = -1;
        apb(1, 0, 32'(`FSPS_CODE_LOAD));
        apb(0, 0, 0);
        chk(rd[7:0] === 8'h01 && err === 1'b0, "armed");
        repeat (1) @(posedge pclk);
        core_u.store(16'h0002, 16'h1234);
        apb(0, 0, 0);
        chk(rd[7:0] === 8'h00, "window expiry");
        apb(1, 0, 32'h07);
        core_u.store(16'h0004, 16'h5678);
        @(posedge pclk);
        chk(cpu_halt === 0, "undefined code");
        op(`FSPS_CODE_ERASE, 7'h40);
        op(`FSPS_CODE_WRITE, 7'h40);
        load(3);
        eeprom_busy <= 1;
        apb(1, 0, 32'(`FSPS_CODE_LOAD));
        core_u.store(16'h0006, 16'h9abc);
        eeprom_busy <= 0;
        foreach (bm[i]) bm[i] = -1;
        op(`FSPS_CODE_ERASE, 7'h33);
        op(`FSPS_CODE_WRITE, 7'h33);
        repeat (4) begin
            lpm_pointer <= {2'b00, 7'h15, 6'($urandom), 1'($urandom)};
            lpm_valid <= 1;
            @(posedge pclk);
            lpm_valid <= 0;
            @(posedge pclk);
            fw = core_u.mem[lpm_pointer[13:1]];
            chk(lpm_byte_valid_q === 1 && lpm_byte_q === fw[lpm_pointer[0]*8 +: 8], "lpm");
        end
        summarize();
    end
    initial begin
        #200000;
        mismatches++;
        summarize();
    end
endmodule
